// [common/lpc_flash_pkg.sv]
package lpc_flash_pkg;

  // ****************************************************************
  // bus encodings
  // ****************************************************************
  localparam logic [3:0]  START_VALID  = 4'h0;
  localparam logic [1:0]  CYC_MEMORY   = 2'b01;
  localparam logic [3:0]  SYNC_READY   = 4'h0;
  localparam logic [3:0]  TAR_DRIVE    = 4'hf;
  localparam logic [2:0]  ADDR_LAST    = 3'h7;
  localparam logic [6:0]  UPPER_ONES   = 7'h7f;
  localparam logic [6:0]  UPPER_ZEROS  = 7'h00;
  localparam int          SPACE_BIT    = 22;

  // ****************************************************************
  // decoded windows and field values
  // ****************************************************************
  localparam logic [14:0] LOW_BOOT_TAG = 15'h0007;
  localparam logic [3:0]  BOOT_ID      = 4'h0;
  localparam logic [19:0] MAKER_ADDR   = 20'h0_0000;
  localparam logic [19:0] PART_ADDR    = 20'h0_0001;
  localparam logic [19:0] GPI_REG_ADDR = 20'h0_0100;
  localparam logic [3:0]  TOP_BLOCK    = 4'hf;
  localparam logic [7:0]  IDLE_BYTE    = 8'h00;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;
  localparam logic [2:0]  CNT_RESET    = 3'h0;

  // a write into the top boot block obeys the lock pin, all else the protect pin
  function automatic logic write_refused(input logic [19:0] addr,
                                         input logic        top_lock_n,
                                         input logic        protect_n);
    if (addr[19:16] == TOP_BLOCK)
      write_refused = !top_lock_n;
    else
      write_refused = !protect_n;
  endfunction : write_refused

endpackage : lpc_flash_pkg

// [common/pp_link_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface pp_link_if;
  logic [19:0] addr;
  logic [7:0]  wdata;
  logic        write;
  logic        read;
  logic [7:0]  rdata;

  modport port (output addr, output wdata, output write, output read, input rdata);
  modport core (input addr, input wdata, input write, input read, output rdata);
endinterface : pp_link_if

`default_nettype wire

// [core/lpc_addr_match.sv]
`timescale 1ns/1ns
`default_nettype none

module lpc_addr_match (
  // address under test
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  strap_identity,
  // decision
  output logic             claim,
  output logic             mem_space
);

  logic upper_ok;
  logic id_ok;
  logic low_boot;

  assign upper_ok = (addr[31:25] == lpc_flash_pkg::UPPER_ONES) ||
                    (addr[31:25] == lpc_flash_pkg::UPPER_ZEROS);
  assign id_ok    = (addr[24:23] == strap_identity[3:2]) &&
                    (addr[21:20] == strap_identity[1:0]);
  // the boot part also mirrors its top two blocks just below 1 MB
  assign low_boot = (addr[31:17] == lpc_flash_pkg::LOW_BOOT_TAG) &&
                    (strap_identity == lpc_flash_pkg::BOOT_ID);
  assign claim     = low_boot || (upper_ok && id_ok && (addr[31:25] == lpc_flash_pkg::UPPER_ONES));
  assign mem_space = low_boot || addr[lpc_flash_pkg::SPACE_BIT];

endmodule : lpc_addr_match

`default_nettype wire

// [core/pp_port.sv]
`timescale 1ns/1ns
`default_nettype none

module pp_port (
  // clocking
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        enable,
  // programmer pins
  input  wire logic        row_col_sel,
  input  wire logic [10:0] pp_addr,
  input  wire logic [7:0]  pp_data_in,
  output logic [7:0]       pp_data_out,
  output logic             pp_data_oe_n,
  input  wire logic        pp_out_en_n,
  input  wire logic        pp_write_en_n,
  // array side
  pp_link_if.port          link
);

  typedef struct packed {
    logic [10:0] row;
    logic [8:0]  col;
    logic [7:0]  wdata;
    logic        we_q;
    logic        write;
    logic [7:0]  dout;
    logic        oe_n;
  } pp_state_t;

  pp_state_t r;
  pp_state_t n;

  always_comb
  begin
    n       = r;
    n.write = 1'b0;
    n.we_q  = pp_write_en_n;
    n.oe_n  = 1'b1;
    if (enable)
    begin
      if (row_col_sel)
        n.row = pp_addr;
      else
        n.col = pp_addr[8:0];
      if (!pp_write_en_n)
        n.wdata = pp_data_in;
      // data is committed on the rising edge of write enable
      n.write = !r.we_q && pp_write_en_n;
      n.oe_n  = pp_out_en_n;
      n.dout  = link.rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '{row: 11'h000, col: 9'h000, wdata: 8'h00, we_q: 1'b1, write: 1'b0, dout: 8'h00, oe_n: 1'b1};
    else if (clk_en)
      r <= n;
  end

  assign link.addr    = {r.col, r.row};
  assign link.wdata   = r.wdata;
  assign link.write   = r.write;
  assign link.read    = !r.oe_n;
  assign pp_data_out  = r.dout;
  assign pp_data_oe_n = r.oe_n;

endmodule : pp_port

`default_nettype wire

// [core/lpc_flash_target.sv]
`timescale 1ns/1ns
`default_nettype none

module lpc_flash_target #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'hc3  // arbitrary value
) (
  // clock and resets
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        init_n,
  input  wire logic        clk_en,
  // configuration straps and pins
  input  wire logic        parallel_program_mode,
  input  wire logic [3:0]  strap_identity,
  input  wire logic [4:0]  general_inputs,
  input  wire logic        top_block_lock_n,
  input  wire logic        write_protect_n,
  input  wire logic        chip_select_n,
  input  wire logic        product_id_mode,
  // bus
  input  wire logic        frame_n,
  input  wire logic [3:0]  lad_in,
  output logic [3:0]       lad_out,
  output logic             lad_oe_n,
  // parallel programming pins
  input  wire logic        row_col_sel,
  input  wire logic [10:0] pp_addr,
  input  wire logic [7:0]  pp_data_in,
  output logic [7:0]       pp_data_out,
  output logic             pp_data_oe_n,
  input  wire logic        pp_out_en_n,
  input  wire logic        pp_write_en_n,
  // flash array
  output logic [19:0]      array_addr,
  output logic [7:0]       array_wdata,
  output logic             array_write,
  output logic             array_read,
  input  wire logic [7:0]  array_rdata,
  // status
  output logic             standby,
  output logic             write_refused
);

  // ****************************************************************
  // reset and state
  // ****************************************************************

  // both reset pins act the same, so one gated net feeds every flop
  logic rst_n;
  assign rst_n = reset_n & init_n;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'b0000_0001,
    ST_START   = 8'b0000_0010,
    ST_ADDR    = 8'b0000_0100,
    ST_WDATA   = 8'b0000_1000,
    ST_TAR_IN  = 8'b0001_0000,
    ST_SYNC    = 8'b0010_0000,
    ST_RDATA   = 8'b0100_0000,
    ST_TAR_OUT = 8'b1000_0000
  } cyc_state_t;

  typedef struct packed {
    cyc_state_t  state;
    logic [3:0]  start_nib;
    logic        cs_n_q;
    logic        is_write;
    logic        mem_sel;
    logic [2:0]  cnt;
    logic [31:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [3:0]  lad_out;
    logic        lad_oe_n;
    logic        write;
    logic        read;
    logic        refused;
    logic        standby;
  } core_state_t;

  core_state_t r;
  core_state_t n;

  // ****************************************************************
  // address decode and parallel port
  // ****************************************************************

  logic [31:0] addr_shift;
  logic        addr_claim;
  logic        addr_mem;

  assign addr_shift = {r.addr[27:0], lad_in};

  lpc_addr_match u_match (
    .addr           (addr_shift),
    .strap_identity (strap_identity),
    .claim          (addr_claim),
    .mem_space      (addr_mem)
  );

  pp_link_if pp_link ();

  // the mode pin is only read, never latched: its pull-down sits in the pad
  logic pp_on;
  assign pp_on = parallel_program_mode;

  pp_port u_pp (
    .clk           (clk),
    .rst_n         (rst_n),
    .clk_en        (clk_en),
    .enable        (pp_on),
    .row_col_sel   (row_col_sel),
    .pp_addr       (pp_addr),
    .pp_data_in    (pp_data_in),
    .pp_data_out   (pp_data_out),
    .pp_data_oe_n  (pp_data_oe_n),
    .pp_out_en_n   (pp_out_en_n),
    .pp_write_en_n (pp_write_en_n),
    .link          (pp_link.port)
  );

  assign pp_link.rdata = array_rdata;

  // ****************************************************************
  // read data selection
  // ****************************************************************

  logic [7:0] read_byte;

  always_comb
  begin
    read_byte = lpc_flash_pkg::IDLE_BYTE;
    if (r.mem_sel)
    begin
      if (product_id_mode && r.addr[19:0] == lpc_flash_pkg::MAKER_ADDR)
        read_byte = MAKER_CODE;
      else if (product_id_mode && r.addr[19:0] == lpc_flash_pkg::PART_ADDR)
        read_byte = PART_CODE;
      else
        read_byte = array_rdata;
    end
    else if (r.addr[19:0] == lpc_flash_pkg::GPI_REG_ADDR)
      // pins are sampled live in the turnaround; the board must hold them
      read_byte = {3'b000, general_inputs};
  end

  // ****************************************************************
  // cycle machine
  // ****************************************************************

  always_comb
  begin
    n          = r;
    n.write    = 1'b0;
    n.read     = 1'b0;
    n.lad_oe_n = 1'b1;
    n.lad_out  = lpc_flash_pkg::TAR_DRIVE;
    n.cs_n_q   = chip_select_n;
    case (r.state)
      ST_IDLE:
      begin
        n.cnt = lpc_flash_pkg::CNT_RESET;
      end
      ST_START:
      begin
        // frame just went high: the last nibble seen under it was the start
        if (frame_n)
        begin
          if (r.start_nib == lpc_flash_pkg::START_VALID && !r.cs_n_q &&
              lad_in[3:2] == lpc_flash_pkg::CYC_MEMORY)
          begin
            n.state    = ST_ADDR;
            n.is_write = lad_in[1];
            n.cnt      = lpc_flash_pkg::CNT_RESET;
          end
          else
            n.state = ST_IDLE;
        end
      end
      ST_ADDR:
      begin
        n.addr = addr_shift;
        n.cnt  = r.cnt + 3'h1;
        if (r.cnt == lpc_flash_pkg::ADDR_LAST)
        begin
          n.cnt     = lpc_flash_pkg::CNT_RESET;
          n.mem_sel = addr_mem;
          if (!addr_claim)
            n.state = ST_IDLE;
          else if (r.is_write)
            n.state = ST_WDATA;
          else
          begin
            n.state = ST_TAR_IN;
            n.read  = addr_mem;
          end
        end
      end
      ST_WDATA:
      begin
        // data arrives low nibble first
        n.cnt = r.cnt + 3'h1;
        if (r.cnt == lpc_flash_pkg::CNT_RESET)
          n.wdata[3:0] = lad_in;
        else
        begin
          n.wdata[7:4] = lad_in;
          n.cnt        = lpc_flash_pkg::CNT_RESET;
          n.state      = ST_TAR_IN;
        end
      end
      ST_TAR_IN:
      begin
        // host drives ones in the first clock; we take the bus on the second
        n.cnt      = r.cnt + 3'h1;
        n.lad_oe_n = 1'b0;
        if (r.cnt != lpc_flash_pkg::CNT_RESET)
        begin
          n.cnt     = lpc_flash_pkg::CNT_RESET;
          n.state   = ST_SYNC;
          n.lad_out = lpc_flash_pkg::SYNC_READY;
          n.rdata   = read_byte;
          if (r.is_write && r.mem_sel)
          begin
            n.refused = lpc_flash_pkg::write_refused(r.addr[19:0], top_block_lock_n,
                                                     write_protect_n);
            n.write   = !n.refused;
          end
        end
      end
      ST_SYNC:
      begin
        n.lad_oe_n = 1'b0;
        if (r.is_write)
          n.state = ST_TAR_OUT;
        else
        begin
          n.state   = ST_RDATA;
          n.lad_out = r.rdata[3:0];
        end
      end
      ST_RDATA:
      begin
        n.lad_oe_n = 1'b0;
        n.cnt      = r.cnt + 3'h1;
        if (r.cnt == lpc_flash_pkg::CNT_RESET)
          n.lad_out = r.rdata[7:4];
        else
        begin
          n.cnt   = lpc_flash_pkg::CNT_RESET;
          n.state = ST_TAR_OUT;
        end
      end
      ST_TAR_OUT:
      begin
        // drive ones for one clock, then release for the second
        n.cnt = r.cnt + 3'h1;
        if (r.cnt != lpc_flash_pkg::CNT_RESET)
        begin
          n.cnt   = lpc_flash_pkg::CNT_RESET;
          n.state = ST_IDLE;
        end
      end
      default:
      begin
        n.state = ST_IDLE;
      end
    endcase

    // frame low wins over everything except parallel mode, including a cycle half done
    if (!frame_n)
    begin
      n.state     = ST_START;
      n.start_nib = lad_in;
      n.lad_oe_n  = 1'b1;
      n.lad_out   = lpc_flash_pkg::TAR_DRIVE;
      n.write     = 1'b0;
      n.read      = 1'b0;
    end

    if (pp_on)
    begin
      n.state    = ST_IDLE;
      n.lad_oe_n = 1'b1;
      n.write    = 1'b0;
      n.read     = 1'b0;
    end

    // standby once deselected and nothing left to finish
    n.standby = chip_select_n && (n.state == ST_IDLE) && !n.write;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r.state     <= ST_IDLE;
      r.start_nib <= lpc_flash_pkg::TAR_DRIVE;
      r.cs_n_q    <= 1'b1;
      r.is_write  <= 1'b0;
      r.mem_sel   <= 1'b0;
      r.cnt       <= lpc_flash_pkg::CNT_RESET;
      r.addr      <= lpc_flash_pkg::ADDR_RESET;
      r.wdata     <= lpc_flash_pkg::IDLE_BYTE;
      r.rdata     <= lpc_flash_pkg::IDLE_BYTE;
      r.lad_out   <= lpc_flash_pkg::TAR_DRIVE;
      r.lad_oe_n  <= 1'b1;
      r.write     <= 1'b0;
      r.read      <= 1'b0;
      r.refused   <= 1'b0;
      r.standby   <= 1'b1;
    end
    else if (clk_en)
      r <= n;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  assign lad_out       = r.lad_out;
  assign lad_oe_n      = r.lad_oe_n;
  assign array_addr    = pp_on ? pp_link.addr  : r.addr[19:0];
  assign array_wdata   = pp_on ? pp_link.wdata : r.wdata;
  assign array_write   = pp_on ? pp_link.write : r.write;
  assign array_read    = pp_on ? pp_link.read  : r.read;
  assign standby       = r.standby;
  assign write_refused = r.refused;

endmodule : lpc_flash_target

`default_nettype wire

// [sim/lpc_flash_target_monitor.sv]
`timescale 1ns/1ns
`default_nettype none

module lpc_flash_target_monitor (
  // clock and resets
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       init_n,
  input wire logic       clk_en,
  // mode and select
  input wire logic       parallel_program_mode,
  input wire logic       chip_select_n,
  // bus
  input wire logic       frame_n,
  input wire logic [3:0] lad_out,
  input wire logic       lad_oe_n,
  // parallel and array side
  input wire logic       pp_data_oe_n,
  input wire logic       array_write,
  input wire logic       array_read,
  input wire logic       standby
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n || !init_n);

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_reset_quiet: assert property (disable iff (1'b0) (!reset_n || !init_n) |-> (lad_oe_n && standby && !array_write))
    else $error("bus driven or write seen during reset");
  a_frame_abort: assert property ((!frame_n && clk_en) |=> lad_oe_n)
    else $error("bus still driven after a new frame");
  a_mode_quiet: assert property (parallel_program_mode |-> lad_oe_n)
    else $error("bus driven in parallel mode");
  a_bus_pp_idle: assert property (!parallel_program_mode |-> pp_data_oe_n)
    else $error("parallel data driven in bus mode");
  a_select_wakes: assert property ((!chip_select_n && clk_en) |=> !standby)
    else $error("standby held while selected");
  a_sync_follows: assert property (($fell(lad_oe_n) && frame_n) |->
    (lad_out == lpc_flash_pkg::TAR_DRIVE) ##1 (!lad_oe_n && lad_out == lpc_flash_pkg::SYNC_READY))
    else $error("sync nibble missing after bus takeover");
  a_drive_bound: assert property ($fell(lad_oe_n) |-> ##[1:5] lad_oe_n)
    else $error("bus not handed back in time");
  a_write_at_sync: assert property ((array_write && !parallel_program_mode) |->
    (!lad_oe_n && lad_out == lpc_flash_pkg::SYNC_READY))
    else $error("array write outside sync cycle");
  a_read_turn: assert property ((!parallel_program_mode && array_read && frame_n) ##1 frame_n |->
    (!lad_oe_n && lad_out == lpc_flash_pkg::TAR_DRIVE) ##1 (lad_out == lpc_flash_pkg::SYNC_READY))
    else $error("read turnaround or sync wrong");

  c_read: cover property (!parallel_program_mode && array_read);
  c_write: cover property (!parallel_program_mode && array_write);
  c_long_start: cover property (!frame_n ##1 !frame_n ##1 frame_n);
endmodule : lpc_flash_target_monitor

bind lpc_flash_target lpc_flash_target_monitor lpc_flash_target_monitor_i (
  .clk(clk), .reset_n(reset_n), .init_n(init_n), .clk_en(clk_en),
  .parallel_program_mode(parallel_program_mode), .chip_select_n(chip_select_n),
  .frame_n(frame_n), .lad_out(lad_out), .lad_oe_n(lad_oe_n), .pp_data_oe_n(pp_data_oe_n),
  .array_write(array_write), .array_read(array_read), .standby(standby)
);

`default_nettype wire

// [sim/lpc_host_model.sv]
`timescale 1ns/1ns
`default_nettype none

module lpc_host_model (
  // clock
  input  wire logic       clk,
  // bus
  output logic            frame_n,
  output logic [3:0]      lad_bus,
  input  wire logic [3:0] lad_out,
  input  wire logic       lad_oe_n
);
  logic       drv;
  logic [3:0] lad;
  logic [4:0] got[6];

  // released lines float to the pull-up level, never to a stale nibble
  assign lad_bus = !lad_oe_n ? lad_out : (drv ? lad : 4'hf);

  initial
  begin
    frame_n = 1'b1;
    drv     = 1'b0;
    lad     = 4'hf;
  end

  task automatic put(input logic f, input logic [3:0] n);
    @(negedge clk);
    frame_n = f;
    drv     = 1'b1;
    lad     = n;
  endtask : put

  // ab > 0 breaks the address phase with a fresh frame after ab-1 nibbles
  task automatic xfer(input logic [3:0] ty, input logic [31:0] a, input logic [7:0] d, input int ab);
    put(1'b0, 4'h5);
    put(1'b0, 4'h0);
    put(1'b1, ty);
    for (int i = 7; i >= 0; i--)
    begin
      if (ab != 0 && i == 8 - ab)
        put(1'b0, 4'hf);
      else
        put(1'b1, a[i*4 +: 4]);
    end
    if (ty[1])
    begin
      put(1'b1, d[3:0]);
      put(1'b1, d[7:4]);
    end
    put(1'b1, 4'hf);
    @(negedge clk);
    drv = 1'b0;
    // sampled at the falling edge, where the device's registered outputs have settled
    for (int i = 0; i < 6; i++)
    begin
      got[i] = {lad_oe_n, lad_out};
      @(negedge clk);
    end
  endtask : xfer
endmodule : lpc_host_model

`default_nettype wire

// [sim/lpc_flash_target_bench.sv]
`timescale 1ns/1ns
`default_nettype none

module lpc_flash_target_bench;
  typedef struct packed {
    logic [3:0]  ty;
    logic [31:0] a;
    logic [7:0]  d;
    logic        pid;
    logic        wp_n;
    logic        tbl_n;
    logic        drv;
    logic [7:0]  exp;
  } row_t;

  logic        clk = 1'b0;
  logic        reset_n = 1'b1;
  logic        init_n = 1'b1;
  logic        parallel_program_mode = 1'b0;
  logic [4:0]  general_inputs = 5'h15;
  logic [3:0]  strap_identity = 4'h9;
  logic        top_block_lock_n = 1'b1;
  logic        write_protect_n = 1'b1;
  logic        chip_select_n = 1'b0;
  logic        product_id_mode = 1'b0;
  logic        row_col_sel = 1'b0;
  logic [10:0] pp_addr = 11'h000;
  logic [7:0]  pp_data_in = 8'h00;
  logic        pp_out_en_n = 1'b1;
  logic        pp_write_en_n = 1'b1;
  logic        frame_n, lad_oe_n, pp_data_oe_n, array_write, array_read, standby, write_refused;
  logic [3:0]  lad_bus, lad_out;
  logic [7:0]  pp_data_out, array_wdata, array_rdata, wr_data;
  logic [19:0] array_addr, wr_addr;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          n_wr = 0;
  int          cycles = 0;
  int          nw;
  row_t        r;
  // strap identity 1001: memory at ff5x_xxxx, registers at ff1x_xxxx
  row_t        rows[13] = '{
    '{4'h4, 32'hff50_0012, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 8'h2e},
    '{4'h5, 32'hff50_0034, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 8'h08},
    '{4'h4, 32'hff10_0100, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 8'h15},
    '{4'h4, 32'hff10_0104, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00},
    '{4'h4, 32'h7f50_0012, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00},
    '{4'h4, 32'hff60_0012, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00},
    '{4'h0, 32'hff50_0012, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00},
    '{4'h4, 32'hff50_0000, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1, 8'h21},
    '{4'h4, 32'hff50_0001, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1, 8'h9e},
    '{4'h6, 32'hff50_0055, 8'ha7, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00},
    '{4'h6, 32'hff50_0055, 8'ha7, 1'b0, 1'b0, 1'b1, 1'b1, 8'h01},
    '{4'h6, 32'hff5f_0010, 8'h5c, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00},
    '{4'h6, 32'hff5f_0010, 8'h5c, 1'b0, 1'b1, 1'b0, 1'b1, 8'h01}};

  always #10 clk = ~clk;
  // the bench stands in for the flash array
  assign array_rdata = array_addr[7:0] ^ 8'h3c;

  always @(posedge clk)
  begin
    cycles++;
    if (array_write)
    begin
      n_wr++;
      wr_addr = array_addr;
      wr_data = array_wdata;
    end
    if (cycles == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  lpc_host_model lpc_host_model_i (.clk(clk), .frame_n(frame_n), .lad_bus(lad_bus), .lad_out(lad_out),
    .lad_oe_n(lad_oe_n));

  // identification codes are arbitrary
  lpc_flash_target #(.MAKER_CODE(8'h21), .PART_CODE(8'h9e)) lpc_flash_target_i (
    .clk(clk), .reset_n(reset_n), .init_n(init_n), .clk_en(1'b1),
    .parallel_program_mode(parallel_program_mode), .strap_identity(strap_identity), .general_inputs(general_inputs),
    .top_block_lock_n(top_block_lock_n), .write_protect_n(write_protect_n), .chip_select_n(chip_select_n),
    .product_id_mode(product_id_mode), .frame_n(frame_n), .lad_in(lad_bus), .lad_out(lad_out),
    .lad_oe_n(lad_oe_n), .row_col_sel(row_col_sel), .pp_addr(pp_addr), .pp_data_in(pp_data_in),
    .pp_data_out(pp_data_out), .pp_data_oe_n(pp_data_oe_n), .pp_out_en_n(pp_out_en_n),
    .pp_write_en_n(pp_write_en_n), .array_addr(array_addr), .array_wdata(array_wdata),
    .array_write(array_write), .array_read(array_read), .array_rdata(array_rdata), .standby(standby),
    .write_refused(write_refused));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // compare the six sampled bus cycles after the host lets go
  task automatic scan(input row_t q);
    logic [19:0] e;
    int          nd;
    e  = q.ty[1] ? 20'hf_0fff : {4'hf, 4'h0, q.exp[3:0], q.exp[7:4], 4'hf};
    nd = !q.drv ? 0 : (q.ty[1] ? 3 : 5);
    for (int i = 0; i < 6; i++)
    begin
      check("lad_oe_n", {7'h0, lpc_host_model_i.got[i][4]}, {7'h0, i >= nd});
      if (i < nd)
        check("lad_out", {4'h0, lpc_host_model_i.got[i][3:0]}, {4'h0, e[19-4*i -: 4]});
    end
  endtask : scan

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  initial
  begin
    // a real falling edge on reset, so the flops never start out unknown
    #1;
    reset_n = 1'b0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    foreach (rows[k])
    begin
      r = rows[k];
      @(negedge clk);
      product_id_mode = r.pid;
      write_protect_n = r.wp_n;
      top_block_lock_n = r.tbl_n;
      nw = n_wr;
      lpc_host_model_i.xfer(r.ty, r.a, r.d, 0);
      scan(r);
      if (r.ty[1])
      begin
        check("write_refused", {7'h0, write_refused}, {7'h0, r.exp[0]});
        check("array writes", 8'(n_wr - nw), {7'h0, !r.exp[0]});
        if (!r.exp[0])
          check("array data", wr_data, r.d);
      end
      $display("row %0d done", k);
    end
    r = rows[0];
    r.drv = 1'b0;
    lpc_host_model_i.xfer(r.ty, r.a, r.d, 3);
    scan(r);
    lpc_host_model_i.xfer(r.ty, r.a, r.d, 0);
    scan(rows[0]);
    $display("abort test done");
    chip_select_n = 1'b1;
    lpc_host_model_i.xfer(r.ty, r.a, r.d, 0);
    scan(r);
    check("standby", {7'h0, standby}, 8'h01);
    chip_select_n = 1'b0;
    $display("deselect test done");
    strap_identity = 4'h0;
    lpc_host_model_i.xfer(r.ty, 32'h000f_0012, r.d, 0);
    scan(rows[0]);
    strap_identity = 4'h9;
    $display("boot mirror test done");
    fork
      lpc_host_model_i.xfer(r.ty, r.a, r.d, 0);
      begin
        repeat (13) @(posedge clk);
        @(negedge clk);
        init_n = 1'b0;
        #1;
        check("lad_oe_n in init", {7'h0, lad_oe_n}, 8'h01);
      end
    join
    init_n = 1'b1;
    lpc_host_model_i.xfer(r.ty, r.a, r.d, 0);
    scan(rows[0]);
    $display("init test done");
    reset_n = 1'b0;
    parallel_program_mode = 1'b1;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    lpc_host_model_i.xfer(r.ty, r.a, r.d, 0);
    scan(r);
    @(negedge clk);
    row_col_sel = 1'b1;
    pp_addr = 11'h5a3;
    @(negedge clk);
    row_col_sel = 1'b0;
    pp_addr = 11'h06c;
    pp_data_in = 8'hd2;
    pp_write_en_n = 1'b0;
    nw = n_wr;
    @(negedge clk);
    pp_write_en_n = 1'b1;
    pp_out_en_n = 1'b0;
    repeat (3) @(negedge clk);
    check("pp writes", 8'(n_wr - nw), 8'h01);
    check("pp addr lo", wr_addr[7:0], 8'ha3);
    check("pp addr hi", wr_addr[18:11], 8'h6c);
    check("pp data", wr_data, 8'hd2);
    check("pp_data_oe_n", {7'h0, pp_data_oe_n}, 8'h00);
    check("pp_data_out", pp_data_out, 8'h9f);
    $display("parallel test done");
    close_out();
  end
endmodule : lpc_flash_target_bench

`default_nettype wire
